// >>> rtl/csi_pkg.sv
// constants for the core stack and indirect addressing block
// Operation
// - sixteen entry fifteen bit return stack
// - call, computed call, interrupt push the pc
// - return variants pop the stack
// - push and pop leave pc latch alone
// - fault reset off: stack wraps circularly
// - overflow/underflow flags set in every mode
// - five bit pointer, top entry registers
// - push bumps then stores, pop loads then drops
// - fault reset on: reset on over/underflow
// - indirect port aimed at itself: zero, no write
// - pointer is sixteen bits from two bytes
// - low 4k maps to absolute registers
// - linear region walks 80 byte ram blocks
// - common bytes excluded from linear region
// - unimplemented linear locations read zero
// - msb set: low 15 bits address flash
// - flash writes through port are ignored
// - flash access costs one extra cycle
package csi_pkg;
  localparam int STK_DEPTH = 16;
  localparam int PC_W = 15;
  localparam logic [4:0] SP_RST = 5'h1F;
  localparam logic [4:0] SP_FULL = 5'h0F;
  localparam logic [4:0] SP_ONE = 5'h01;
  localparam logic [4:0] SP_LOW = 5'h00;
  // register map, absolute addresses
  localparam logic [11:0] A_SP = 12'hFED;
  localparam logic [11:0] A_TOP_ENTRY_LOW = 12'hFEE;
  localparam logic [11:0] A_TOP_ENTRY_HIGH = 12'hFEF;
  localparam logic [11:0] A_POWER_CONTROL_REG = 12'h096;
  // core registers mirrored in every bank, by offset in bank
  localparam logic [6:0] O_IND0 = 7'h00;
  localparam logic [6:0] O_IND1 = 7'h01;
  localparam logic [6:0] O_P0L = 7'h04;
  localparam logic [6:0] O_P0H = 7'h05;
  localparam logic [6:0] O_P1L = 7'h06;
  localparam logic [6:0] O_P1H = 7'h07;
  localparam logic [6:0] O_PC_HIGH_LATCH = 7'h0A;
  localparam logic [6:0] O_GPR = 7'h20;
  localparam int BIT_OVF = 7;
  localparam int BIT_UNF = 6;
  // pointer regions
  localparam logic [15:0] TRAD_END = 16'h0FFF;
  localparam logic [15:0] LIN_BASE = 16'h2000;
  localparam logic [15:0] LIN_END = 16'h29AF;
  localparam logic [11:0] LIN_BLK = 12'h050;
  localparam int FLASH_BIT = 15;
  localparam int MEM_WORDS = 4096;
endpackage : csi_pkg

// >>> rtl/csi_core.sv
// return stack and indirect addressing decoder of the core
module csi_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire logic stack_fault_reset_enable,
  input wire logic call_evt,
  input wire logic call_via_w_evt,
  input wire logic int_evt,
  input wire logic return_evt,
  input wire logic return_with_literal_evt,
  input wire logic return_from_interrupt_evt,
  input wire logic [14:0] pc_in,
  output logic [14:0] ret_pc,
  output logic ret_pc_valid,
  output logic stack_fault_reset,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic [14:0] flash_addr0,
  output logic [14:0] flash_addr1,
  input wire logic [13:0] flash_data0,
  input wire logic [13:0] flash_data1,
  output logic flash_stall,
  output logic [6:0] pc_high_latch
);

  // ****************************************
  // stack state
  // ****************************************
  logic [14:0] stk_r [0:csi_pkg::STK_DEPTH-1];
  logic [4:0] sp_r;
  logic [4:0] sp_nxt;
  logic [7:0] power_control_reg_r;
  logic [15:0] fsr0_r;
  logic [15:0] fsr1_r;
  logic [6:0] pc_high_latch_r;
  logic [7:0] mem [0:csi_pkg::MEM_WORDS-1];
  logic push;
  logic pop;
  logic ovf;
  logic unf;

  assign push = call_evt | call_via_w_evt | int_evt;
  assign pop = (return_evt | return_with_literal_evt | return_from_interrupt_evt)
    & ~push;
  assign ovf = push & (sp_r == csi_pkg::SP_FULL);
  assign unf = pop & (sp_r == csi_pkg::SP_RST);

  // ****************************************
  // access decode
  // ****************************************
  logic ind_sel;
  logic [15:0] fsr_sel;
  logic [11:0] ea;
  logic ea_ok;
  logic is_flash;
  logic self_ref;
  logic [11:0] lin_n;
  logic [4:0] lin_bank;
  logic [6:0] lin_off;
  logic [13:0] flash_word;
  logic acc_wr;
  logic acc_rd;
  logic [7:0] rd_val;

  always_comb begin
    ind_sel = (addr[6:0] == csi_pkg::O_IND0) || (addr[6:0] == csi_pkg::O_IND1);
    fsr_sel = (addr[6:0] == csi_pkg::O_IND1) ? fsr1_r : fsr0_r;
    flash_word = (addr[6:0] == csi_pkg::O_IND1) ? flash_data1 : flash_data0;
    lin_n = fsr_sel[11:0] - csi_pkg::LIN_BASE[11:0];
    lin_bank = 5'(lin_n / csi_pkg::LIN_BLK);
    lin_off = 7'(lin_n - 12'(lin_bank * csi_pkg::LIN_BLK)) + csi_pkg::O_GPR;
    is_flash = 1'b0;
    ea = addr;
    ea_ok = 1'b1;
    if (ind_sel) begin
      if (fsr_sel[csi_pkg::FLASH_BIT]) begin
        is_flash = 1'b1;
        ea_ok = 1'b0;
      end else if (fsr_sel <= csi_pkg::TRAD_END) begin
        ea = fsr_sel[11:0];
      end else if (fsr_sel >= csi_pkg::LIN_BASE && fsr_sel <= csi_pkg::LIN_END) begin
        ea = {lin_bank, lin_off};
      end else begin
        ea_ok = 1'b0;
      end
    end
    // pointer aimed at an indirect port itself
    self_ref = ind_sel && ea_ok &&
      ((ea[6:0] == csi_pkg::O_IND0) || (ea[6:0] == csi_pkg::O_IND1));
    acc_wr = wr && ea_ok && !self_ref;
    acc_rd = rd && ea_ok && !self_ref;
  end

  always_comb begin
    rd_val = 8'h00;
    if (rd && is_flash) begin
      rd_val = flash_word[7:0];
    end else if (acc_rd) begin
      if (ea == csi_pkg::A_SP) begin
        rd_val = {3'h0, sp_r};
      end else if (ea == csi_pkg::A_TOP_ENTRY_LOW) begin
        rd_val = stk_r[sp_r[3:0]][7:0];
      end else if (ea == csi_pkg::A_TOP_ENTRY_HIGH) begin
        rd_val = {1'b0, stk_r[sp_r[3:0]][14:8]};
      end else if (ea == csi_pkg::A_POWER_CONTROL_REG) begin
        rd_val = power_control_reg_r;
      end else begin
        case (ea[6:0])
          csi_pkg::O_P0L: rd_val = fsr0_r[7:0];
          csi_pkg::O_P0H: rd_val = fsr0_r[15:8];
          csi_pkg::O_P1L: rd_val = fsr1_r[7:0];
          csi_pkg::O_P1H: rd_val = fsr1_r[15:8];
          csi_pkg::O_PC_HIGH_LATCH: rd_val = {1'b0, pc_high_latch_r};
          default: rd_val = mem[ea];
        endcase
      end
    end
  end

  logic wr_core;
  assign wr_core = (ea[6:0] == csi_pkg::O_P0L) || (ea[6:0] == csi_pkg::O_P0H) ||
    (ea[6:0] == csi_pkg::O_P1L) || (ea[6:0] == csi_pkg::O_P1H) ||
    (ea[6:0] == csi_pkg::O_PC_HIGH_LATCH) || (ea == csi_pkg::A_SP) ||
    (ea == csi_pkg::A_TOP_ENTRY_LOW) || (ea == csi_pkg::A_TOP_ENTRY_HIGH) || (ea == csi_pkg::A_POWER_CONTROL_REG);

  // ****************************************
  // read data and flash timing
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? rd_val : 8'h00;
    end
  end

  // the core holds off one instruction cycle after a flash read or write through the port
  always_ff @(posedge clk) begin
    if (rst) begin
      flash_stall <= 1'b0;
    end else begin
      flash_stall <= (rd | wr) & is_flash;
    end
  end

  // ****************************************
  // pointer and latch registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      fsr0_r <= 16'h0000;
      fsr1_r <= 16'h0000;
    end else if (acc_wr) begin
      case (ea[6:0])
        csi_pkg::O_P0L: fsr0_r[7:0] <= wdata;
        csi_pkg::O_P0H: fsr0_r[15:8] <= wdata;
        csi_pkg::O_P1L: fsr1_r[7:0] <= wdata;
        csi_pkg::O_P1H: fsr1_r[15:8] <= wdata;
        default: ;
      endcase
    end
  end

  assign flash_addr0 = fsr0_r[14:0];
  assign flash_addr1 = fsr1_r[14:0];

  // only software touches the latch; stack traffic never does
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_high_latch_r <= 7'h00;
    end else if (acc_wr && ea[6:0] == csi_pkg::O_PC_HIGH_LATCH) begin
      pc_high_latch_r <= wdata[6:0];
    end
  end
  assign pc_high_latch = pc_high_latch_r;

  always_ff @(posedge clk) begin
    if (acc_wr && !wr_core) begin
      mem[ea] <= wdata;
    end
  end

  // ****************************************
  // stack pointer and entries
  // ****************************************
  always_comb begin
    sp_nxt = sp_r;
    if (push) begin
      sp_nxt = ovf ? csi_pkg::SP_LOW : 5'(sp_r + csi_pkg::SP_ONE);
    end else if (pop) begin
      sp_nxt = unf ? csi_pkg::SP_FULL : 5'(sp_r - csi_pkg::SP_ONE);
    end else if (acc_wr && ea == csi_pkg::A_SP) begin
      sp_nxt = wdata[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sp_r <= csi_pkg::SP_RST;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // entries hold no reset; contents are unknown until pushed
  always_ff @(posedge clk) begin
    if (push) begin
      stk_r[sp_nxt[3:0]] <= pc_in;
    end else if (acc_wr && ea == csi_pkg::A_TOP_ENTRY_LOW) begin
      stk_r[sp_r[3:0]][7:0] <= wdata;
    end else if (acc_wr && ea == csi_pkg::A_TOP_ENTRY_HIGH) begin
      stk_r[sp_r[3:0]][14:8] <= wdata[6:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ret_pc <= 15'h0000;
      ret_pc_valid <= 1'b0;
    end else begin
      ret_pc_valid <= pop;
      if (pop) begin
        ret_pc <= stk_r[sp_r[3:0]];
      end
    end
  end

  // ****************************************
  // fault flags and fault reset
  // ****************************************
  // flags survive the core reset so software can see why it restarted
  always_ff @(posedge clk) begin
    if (por) begin
      power_control_reg_r <= 8'h00;
    end else begin
      if (acc_wr && ea == csi_pkg::A_POWER_CONTROL_REG) begin
        power_control_reg_r <= wdata;
      end
      if (ovf) begin
        power_control_reg_r[csi_pkg::BIT_OVF] <= 1'b1;
      end
      if (unf) begin
        power_control_reg_r[csi_pkg::BIT_UNF] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stack_fault_reset <= 1'b0;
    end else begin
      stack_fault_reset <= stack_fault_reset_enable & (ovf | unf);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_push_inc;
    @(posedge clk) disable iff (rst)
    push && !ovf |=> sp_r == 5'($past(sp_r) + csi_pkg::SP_ONE);
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("push did not bump pointer");

  property p_push_store;
    @(posedge clk) disable iff (rst)
    push |=> stk_r[sp_r[3:0]] == $past(pc_in);
  endproperty
  a_push_store: assert property (p_push_store) else $error("pushed pc not stored");

  property p_pop_load;
    @(posedge clk) disable iff (rst)
    pop && !unf |=> ret_pc_valid && ret_pc == $past(stk_r[sp_r[3:0]]) &&
      sp_r == 5'($past(sp_r) - csi_pkg::SP_ONE);
  endproperty
  a_pop_load: assert property (p_pop_load) else $error("pop order wrong");

  property p_latch_kept;
    @(posedge clk) disable iff (rst)
    (push || pop) && !wr |=> $stable(pc_high_latch);
  endproperty
  a_latch_kept: assert property (p_latch_kept) else $error("latch moved by stack");

  property p_wrap;
    @(posedge clk) disable iff (rst)
    push && sp_r == csi_pkg::SP_FULL |=> sp_r == csi_pkg::SP_LOW;
  endproperty
  a_wrap: assert property (p_wrap) else $error("stack did not wrap");

  property p_flags;
    @(posedge clk) disable iff (por)
    (ovf |=> power_control_reg_r[csi_pkg::BIT_OVF]) and (unf |=> power_control_reg_r[csi_pkg::BIT_UNF]);
  endproperty
  a_flags: assert property (p_flags) else $error("fault flag not set");

  property p_fault_rst;
    @(posedge clk) disable iff (rst)
    (ovf || unf) && stack_fault_reset_enable |=> stack_fault_reset;
  endproperty
  a_fault_rst: assert property (p_fault_rst) else $error("fault reset missing");

  // pulse must end, or the core would sit in reset
  property p_no_fault;
    @(posedge clk) disable iff (rst)
    !((ovf || unf) && stack_fault_reset_enable) |=> !stack_fault_reset;
  endproperty
  a_no_fault: assert property (p_no_fault) else $error("spurious fault reset");

  property p_sp_reset;
    @(posedge clk)
    rst |=> sp_r == csi_pkg::SP_RST;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("pointer not placed by reset");

  property p_unf_wrap;
    @(posedge clk) disable iff (rst)
    pop && sp_r == csi_pkg::SP_RST |=> sp_r == csi_pkg::SP_FULL;
  endproperty
  a_unf_wrap: assert property (p_unf_wrap) else $error("underflow did not wrap");

  property p_valid_pulse;
    @(posedge clk) disable iff (rst)
    !pop |=> !ret_pc_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("return valid without pop");

  // common bytes sit above the block, so a mapped offset never reaches them
  property p_lin_common;
    @(posedge clk) disable iff (rst)
    ind_sel && fsr_sel >= csi_pkg::LIN_BASE && fsr_sel <= csi_pkg::LIN_END |->
      ea[6:0] >= csi_pkg::O_GPR && ea[6:0] < 7'(csi_pkg::O_GPR + csi_pkg::LIN_BLK);
  endproperty
  a_lin_common: assert property (p_lin_common) else $error("linear hit common bytes");

  property p_power_control_reg_sticky;
    @(posedge clk) disable iff (por)
    power_control_reg_r[csi_pkg::BIT_OVF] && !(acc_wr && ea == csi_pkg::A_POWER_CONTROL_REG) |=> power_control_reg_r[csi_pkg::BIT_OVF];
  endproperty
  a_power_control_reg_sticky: assert property (p_power_control_reg_sticky) else $error("overflow flag lost");

  property p_flash_wr;
    @(posedge clk) disable iff (rst)
    wr && is_flash |=> flash_stall;
  endproperty
  a_flash_wr: assert property (p_flash_wr) else $error("flash write did not stall");

  property p_self_zero;
    @(posedge clk) disable iff (rst)
    rd && self_ref |=> rdata == 8'h00;
  endproperty
  a_self_zero: assert property (p_self_zero) else $error("self reference read");

  property p_flash_stall;
    @(posedge clk) disable iff (rst)
    rd && is_flash |=> flash_stall && rdata == $past(flash_word[7:0]);
  endproperty
  a_flash_stall: assert property (p_flash_stall) else $error("flash access wrong");

  property p_reserved;
    @(posedge clk) disable iff (rst)
    rd && ind_sel && !is_flash && !ea_ok |=> rdata == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved read not zero");

  c_push: cover property (@(posedge clk) disable iff (rst) push ##[1:8] pop);
  c_unf: cover property (@(posedge clk) disable iff (rst) unf && stack_fault_reset_enable);
  c_ovf: cover property (@(posedge clk) disable iff (rst) ovf);
  c_flash: cover property (@(posedge clk) disable iff (rst) rd && is_flash);
  c_lin: cover property (@(posedge clk) disable iff (rst)
    wr && ind_sel && fsr_sel >= csi_pkg::LIN_BASE && ea_ok);

endmodule : csi_core

// >>> sim/csi_core_tb.sv
// self-checking bench for the return stack and indirect decoder
module csi_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // signals and design
  // ********************************
  logic clk, rst, por, fault_en, wr, rd, rv, special_function_register, fst;
  logic [2:0] push_ev, pop_ev;
  logic [14:0] pc_in, ret_pc, fa0, fa1;
  logic [11:0] addr;
  logic [7:0] wdata, rdata;
  logic [13:0] fd0, fd1;
  logic [6:0] latch;
  int num_errors = 0;
  int checks = 0;
  // flash image: address folded with a pattern, so a wrong address shows
  assign fd0 = fa0[13:0] ^ 14'h2A5A;
  assign fd1 = fa1[13:0] ^ 14'h1C3C;
  csi_core u_csi_core (.clk(clk), .rst(rst), .por(por), .stack_fault_reset_enable(fault_en),
    .call_evt(push_ev[0]), .call_via_w_evt(push_ev[1]), .int_evt(push_ev[2]),
    .return_evt(pop_ev[0]), .return_with_literal_evt(pop_ev[1]),
    .return_from_interrupt_evt(pop_ev[2]), .pc_in(pc_in), .ret_pc(ret_pc), .ret_pc_valid(rv),
    .stack_fault_reset(special_function_register), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .flash_addr0(fa0), .flash_addr1(fa1), .flash_data0(fd0), .flash_data1(fd1),
    .flash_stall(fst), .pc_high_latch(latch));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ********************************
  // tasks
  // ********************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e, input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(16'(rdata), 16'(e), what);
  endtask : rd_chk
  task automatic push(input int k, input logic [14:0] pc);
    @(posedge clk);
    push_ev <= 3'h1 << k;
    pc_in <= pc;
    @(posedge clk);
    push_ev <= 3'h0;
    #1;
  endtask : push
  task automatic pop(input int k, input logic [14:0] e);
    @(posedge clk);
    pop_ev <= 3'h1 << k;
    @(posedge clk);
    pop_ev <= 3'h0;
    #1;
    check(16'(rv), 16'h0001, "pop valid");
    check(16'(ret_pc), 16'(e), "pop pc");
  endtask : pop
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
  endtask : do_reset
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  // ********************************
  // tests
  // ********************************
  initial begin
    rst = 1'b1;
    por = 1'b1;
    fault_en = 1'b0;
    push_ev = 3'h0;
    pop_ev = 3'h0;
    pc_in = 15'h0000;
    addr = 12'h000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    rd_chk(csi_pkg::A_SP, 8'h1F, "ptr at reset");
    rd_chk(csi_pkg::A_POWER_CONTROL_REG, 8'h00, "flags at reset");
    wr_reg(12'h00A, 8'h55);
    push(0, 15'h1234);
    push(1, 15'h7ABC);
    push(2, 15'h0F0F);
    rd_chk(csi_pkg::A_SP, 8'h02, "ptr after pushes");
    rd_chk(csi_pkg::A_TOP_ENTRY_LOW, 8'h0F, "top low");
    pop(2, 15'h0F0F);
    pop(1, 15'h7ABC);
    pop(0, 15'h1234);
    @(posedge clk);
    #1;
    check(16'(rv), 16'h0000, "valid one cycle");
    rd_chk(csi_pkg::A_SP, 8'h1F, "ptr after pops");
    check(16'(latch), 16'h0055, "latch kept");
    $display("test stack_basic done");
    for (int i = 0; i < 17; i++) begin
      push(0, 15'h0100 + 15'(i));
      check(16'(special_function_register), 16'h0000, "no fault reset in wrap mode");
    end
    rd_chk(csi_pkg::A_SP, 8'h00, "ptr wrapped");
    rd_chk(csi_pkg::A_POWER_CONTROL_REG, 8'h80, "overflow flag");
    wr_reg(csi_pkg::A_SP, 8'h03);
    rd_chk(csi_pkg::A_TOP_ENTRY_HIGH, 8'h01, "entry 3 high");
    wr_reg(csi_pkg::A_TOP_ENTRY_LOW, 8'hAB);
    rd_chk(csi_pkg::A_TOP_ENTRY_LOW, 8'hAB, "entry 3 written");
    wr_reg(csi_pkg::A_SP, 8'h00);
    pop(0, 15'h0110);
    pop(0, 15'h010F);
    rd_chk(csi_pkg::A_POWER_CONTROL_REG, 8'hC0, "underflow flag");
    $display("test stack_wrap done");
    wr_reg(csi_pkg::A_POWER_CONTROL_REG, 8'h00);
    do_reset;
    fault_en <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      push(1, 15'h0200 + 15'(i));
      check(16'(special_function_register), 16'(i == 16), "fault reset on overflow");
    end
    @(posedge clk);
    #1;
    check(16'(special_function_register), 16'h0000, "fault reset one pulse");
    do_reset;
    rd_chk(csi_pkg::A_POWER_CONTROL_REG, 8'h80, "flag survives reset");
    pop(2, 15'h020F);
    check(16'(special_function_register), 16'h0001, "fault reset on underflow");
    fault_en <= 1'b0;
    $display("test stack_fault done");
    // linear offset 0x50 starts bank 1's block
    wr_reg(12'h005, 8'h20);
    wr_reg(12'h004, 8'h50);
    wr_reg(12'h000, 8'h66);
    rd_chk(12'h0A0, 8'h66, "linear bank step");
    check(16'(fst), 16'h0000, "no stall on data");
    wr_reg(12'h007, 8'h29);
    wr_reg(12'h006, 8'hAF);
    wr_reg(12'h001, 8'h5C);
    rd_chk(12'hF6F, 8'h5C, "last linear byte");
    wr_reg(12'h007, 8'h01);
    wr_reg(12'h006, 8'h23);
    wr_reg(12'h001, 8'h3E);
    rd_chk(12'h123, 8'h3E, "traditional map");
    wr_reg(12'h005, 8'h00);
    wr_reg(12'h004, 8'h01);
    rd_chk(12'h000, 8'h00, "port aimed at port");
    wr_reg(12'h520, 8'h11);
    wr_reg(12'h005, 8'h15);
    wr_reg(12'h004, 8'h20);
    wr_reg(12'h000, 8'h44);
    rd_chk(12'h000, 8'h00, "reserved reads zero");
    rd_chk(12'h520, 8'h11, "reserved write ignored");
    wr_reg(12'h005, 8'h81);
    wr_reg(12'h004, 8'h23);
    rd_chk(12'h000, 8'h79, "flash low byte");
    check(16'(fst), 16'h0001, "flash stall");
    wr_reg(12'h000, 8'hEE);
    check(16'(fst), 16'h0001, "flash write stall");
    rd_chk(12'h000, 8'h79, "flash unchanged");
    rd_chk(12'h123, 8'h3E, "flash write kept out of ram");
    wr_reg(12'h007, 8'hFF);
    wr_reg(12'h006, 8'hFF);
    rd_chk(12'h001, 8'hC3, "flash top word");
    $display("test indirect done");
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end
endmodule : csi_core_tb
